// file: verilog/mhp_port.sv
/*
  Host access port: muxed address/data bus slave with register file,
  power-up access lockout, power-on control and interrupt request.
  Assumes host strobes are asynchronous to clock; two-way pins are
  resolved outside from the output enables.
*/
// Operation
// - The address on the bus is latched on the falling latch strobe.
// - Write data is stored into the addressed register on write rise.
// - Read data is driven only in the later part of the read low time.
// - When read goes high the bus is released.
// - After power-up access is refused for a lockout time, bypassed.
// - Without main power, key or wake interrupt asserts power-on low.
// - With main power, power-on follows a software control bit.
// - The timebase runs from a 32.768 kHz crystal at the osc pins.
// - An external 32.768 kHz clock may drive osc_in instead.
// - Select must be low during the strobe for any access to occur.
// - Interrupt request is low while an enabled flag is set.
`timescale 1ns/1ps
`default_nettype none
module mhp_port
  import mhp_pkg::*;
#(
  parameter int unsigned LOCKOUT_CNT = LOCKOUT_CYCLES
)
(
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             addr_latch_strobe,
  input  wire logic             read_strobe_n,
  input  wire logic             store_strobe_n,
  input  wire logic             device_select_n,
  input  wire logic [7:0]       muxed_bus_in,
  output var  logic [7:0]       muxed_bus_out,
  output var  logic             muxed_bus_oe,
  input  wire logic             main_power,
  input  wire logic             wake_irq,
  input  wire logic             wake_key_in_n,
  output var  logic             power_on_ctl_n_out,
  output var  logic             power_on_ctl_n_oe,
  output var  logic             intr_request_n_out,
  output var  logic             intr_request_n_oe,
  input  wire logic             osc_in,
  output var  logic             osc_out,
  output var  logic             access_ready
);

  initial
  begin
    if (LOCKOUT_CNT < 1)
      $error("LOCKOUT_CNT must be at least one");
  end

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  mhp_host_s  host_m_q, host_q;
  mhp_power_s sup_m_q, sup_q;
  logic       osc_m_q, osc_q;

  // Two flops on every host pin input
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      host_m_q <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1,
                    bus: 8'h00};
      host_q   <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1,
                    bus: 8'h00};
    end
    else
    begin
      host_m_q <= '{ale: addr_latch_strobe, rd_n: read_strobe_n,
                    wr_n: store_strobe_n, cs_n: device_select_n,
                    bus: muxed_bus_in};
      host_q   <= host_m_q;
    end
  end

  // Power and osc synchronisers
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      sup_m_q <= '{main_power: 1'b0, wake_irq: 1'b0, wake_key_n: 1'b1};
      sup_q   <= '{main_power: 1'b0, wake_irq: 1'b0, wake_key_n: 1'b1};
      osc_m_q <= 1'b0;
      osc_q   <= 1'b0;
    end
    else
    begin
      sup_m_q <= '{main_power: main_power, wake_irq: wake_irq,
                   wake_key_n: wake_key_in_n};
      sup_q   <= sup_m_q;
      osc_m_q <= osc_in;
      osc_q   <= osc_m_q;
    end
  end

  // ****************************************************
  // Strobe edges and address latch
  // ****************************************************
  logic       ale_d1_q, wr_d1_q, cs_wr_q;
  logic [7:0] addr_q;
  logic       ale_fall, wr_rise;

  assign ale_fall = ale_d1_q & ~host_q.ale;
  assign wr_rise  = ~wr_d1_q & host_q.wr_n;

  // Edge history
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      ale_d1_q <= 1'b0;
      wr_d1_q  <= 1'b1;
      cs_wr_q  <= 1'b0;
    end
    else
    begin
      ale_d1_q <= host_q.ale;
      wr_d1_q  <= host_q.wr_n;
      // Select must stand through the whole write strobe
      if (wr_d1_q && !host_q.wr_n)
        cs_wr_q <= ~host_q.cs_n;
      else if (!host_q.wr_n && host_q.cs_n)
        cs_wr_q <= 1'b0;
    end
  end

  // Address latch, with or without select
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      addr_q <= 8'h00;
    else if (ale_fall)
      addr_q <= host_q.bus;
  end

  // ****************************************************
  // Power-up lockout
  // ****************************************************
  logic [31:0] lock_cnt_q;
  logic        access_ok;
  logic [7:0]  ctrl_q;
  logic        bypass;

  assign bypass    = ctrl_q[CTRL_OSC_OFF_BIT] | ctrl_q[CTRL_CHAIN_RST_BIT];
  assign access_ok = (lock_cnt_q == 32'h0) | bypass;

  // Counts down from power restore
  always_ff @(posedge clock)
  begin
    if (!rst_b || !sup_q.main_power)
      lock_cnt_q <= LOCKOUT_CNT;
    else if (lock_cnt_q != 32'h0)
      lock_cnt_q <= lock_cnt_q - 32'h1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      access_ready <= 1'b0;
    else
      access_ready <= access_ok & sup_q.main_power;
  end

  // ****************************************************
  // Register file
  // ****************************************************
  logic [7:0] regs_q [NUM_REGS];
  logic       wr_go;

  assign wr_go = wr_rise & cs_wr_q & access_ok & sup_q.main_power;

  // One flop bank per entry
  for (genvar i = 0; i < NUM_REGS; i++)
  begin : g_reg
    always_ff @(posedge clock)
    begin
      if (!rst_b)
        regs_q[i] <= REG_RESET;
      else if (wr_go && addr_q == 8'(i))
        regs_q[i] <= host_q.bus;
    end
  end

  assign ctrl_q = regs_q[CTRL_ADDR[3:0]];

  // ****************************************************
  // Read path
  // ****************************************************
  logic [1:0] rd_cnt_q;
  logic       rd_act;

  assign rd_act = ~host_q.rd_n & ~host_q.cs_n & access_ok
                  & sup_q.main_power;

  // Drive only after a delay into the read low time
  always_ff @(posedge clock)
  begin
    if (!rst_b || !rd_act)
    begin
      rd_cnt_q      <= 2'h0;
      muxed_bus_oe  <= 1'b0;
      muxed_bus_out <= 8'h00;
    end
    else
    begin
      if (rd_cnt_q != 2'(READ_DELAY_CYCLES))
        rd_cnt_q <= rd_cnt_q + 2'h1;
      muxed_bus_oe  <= (rd_cnt_q == 2'(READ_DELAY_CYCLES));
      muxed_bus_out <= (addr_q < 8'(NUM_REGS)) ?
                       regs_q[addr_q[3:0]] : 8'h00;
    end
  end

  // ****************************************************
  // Power-on control, interrupt, oscillator
  // ****************************************************
  logic irq_any;

  assign irq_any = |(regs_q[FLAG_ADDR[3:0]] & regs_q[IEN_ADDR[3:0]]);

  // Open drain power-on and interrupt pins
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      power_on_ctl_n_oe  <= 1'b0;
      intr_request_n_oe  <= 1'b0;
    end
    else
    begin
      if (!sup_q.main_power)
        power_on_ctl_n_oe <= ~sup_q.wake_key_n | sup_q.wake_irq;
      else
        power_on_ctl_n_oe <= ctrl_q[CTRL_PON_BIT];
      intr_request_n_oe <= irq_any;
    end
  end

  assign power_on_ctl_n_out = 1'b0;
  assign intr_request_n_out = 1'b0;

  // Inverting oscillator stage toward the crystal
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      osc_out <= 1'b0;
    else
      osc_out <= ~osc_q & ~ctrl_q[CTRL_OSC_OFF_BIT];
  end

  // ****************************************************
  // Checks
  // ****************************************************
  sequence s_wr_end;
    !host_q.wr_n ##1 host_q.wr_n;
  endsequence

  bus_release_a: assert property (@(posedge clock) disable iff (!rst_b)
    host_q.rd_n |=> !muxed_bus_oe)
    else $error("bus driven after read end");
  read_delay_a: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(muxed_bus_oe) |-> $past(rd_act, 3) && $past(rd_act, 1))
    else $error("read data too early");
  access_lock_a: assert property (@(posedge clock) disable iff (!rst_b)
    (lock_cnt_q != 32'h0 && !bypass) |=> !access_ready && !muxed_bus_oe)
    else $error("access during lockout");
  addr_latch_a: assert property (@(posedge clock) disable iff (!rst_b)
    ale_fall |=> addr_q == $past(host_q.bus))
    else $error("address not latched");
  write_select_a: assert property (@(posedge clock) disable iff (!rst_b)
    wr_go |-> !$past(host_q.cs_n))
    else $error("write without select");
  one_write_a: assert property (@(posedge clock) disable iff (!rst_b)
    wr_go |=> !wr_go)
    else $error("double write");
  wake_drive_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!sup_q.main_power && !sup_q.wake_key_n) |=> power_on_ctl_n_oe)
    else $error("wake key ignored");
  pon_ctl_a: assert property (@(posedge clock) disable iff (!rst_b)
    sup_q.main_power |=> power_on_ctl_n_oe == $past(ctrl_q[CTRL_PON_BIT]))
    else $error("power control mismatch");
  irq_drive_a: assert property (@(posedge clock) disable iff (!rst_b)
    irq_any |=> intr_request_n_oe)
    else $error("interrupt not raised");
  write_data_a: assert property (@(posedge clock) disable iff (!rst_b)
    s_wr_end ##0 (wr_go && addr_q < 8'(NUM_REGS))
    |=> regs_q[addr_q[3:0]] == $past(host_q.bus))
    else $error("write data lost");

endmodule
`default_nettype wire

// file: verilog/mhp_pkg.sv
/*
  Package of the muxed bus host port: timing constants and the
  carrier structs shared by the port logic.
  Assumes a 100 MHz system clock.
*/
`default_nettype none
package mhp_pkg;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned LOCKOUT_MIN_MS     = 20;
  localparam int unsigned LOCKOUT_MAX_MS     = 150;
  localparam int unsigned NS_PER_MS          = 1000000;
  // Lockout count: least time, rounded up
  localparam int unsigned LOCKOUT_CYCLES     =
    (LOCKOUT_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Read data appears this many cycles plus one after read strobe is seen low
  localparam int unsigned READ_DELAY_CYCLES  = 2;
  localparam int unsigned OSC_FREQ_HZ        = 32768;

  // ****************************************************
  // Widths and register layout
  // ****************************************************
  localparam int unsigned DATA_W             = 8;
  localparam int unsigned NUM_REGS           = 16;
  localparam logic [7:0]  REG_RESET          = 8'h00;
  localparam logic [7:0]  CTRL_ADDR          = 8'h0a;
  localparam int unsigned CTRL_PON_BIT       = 0;
  localparam int unsigned CTRL_OSC_OFF_BIT   = 1;
  localparam int unsigned CTRL_CHAIN_RST_BIT = 2;
  localparam logic [7:0]  FLAG_ADDR          = 8'h0c;
  localparam logic [7:0]  IEN_ADDR           = 8'h0b;

  // ****************************************************
  // Carrier types
  // ****************************************************
  typedef struct packed {
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic       cs_n;
    logic [7:0] bus;
  } mhp_host_s;

  typedef struct packed {
    logic       main_power;
    logic       wake_irq;
    logic       wake_key_n;
  } mhp_power_s;

endpackage
`default_nettype wire

// file: verif/mhp_host_model.sv
/*
  Host processor model driving muxed bus cycles.
  Assumes the bench clock; the bench calls its tasks.
*/
`timescale 1ns/1ps
`default_nettype none
module mhp_host_model
  import mhp_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [7:0] dev_data,
  input  wire logic       dev_oe,
  output var  logic [7:0] bus,
  output var  mhp_host_s  h
);
  // ******
  // Bus cycles
  // ******
  logic       hold = 1'b0;
  logic [7:0] last = 8'h00;
  initial h = '{1'b0, 1'b1, 1'b1, 1'b1, 8'h00};
  // Released bus shows inverse of last level
  always_comb bus = dev_oe ? dev_data : (hold ? h.bus : ~last);
  // Last bus level
  always @(posedge clock) last <= bus;
  // Address phase, held past the latch
  task automatic addr(input logic [7:0] a);
    @(posedge clock);
    h.ale <= 1'b1;
    h.bus <= a;
    hold  <= 1'b1;
    @(posedge clock);
    h.ale <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  // Write cycle, select optional
  task automatic write(input logic [7:0] a, input logic [7:0] d,
                       input logic sel);
    addr(a);
    h.cs_n <= ~sel;
    h.wr_n <= 1'b0;
    h.bus  <= d;
    repeat (6) @(posedge clock);
    h.wr_n <= 1'b1;
    @(posedge clock);
    h.cs_n <= 1'b1;
    hold   <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
  // Read cycle, counts edges to drive and release
  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output int ton, output int toff);
    addr(a);
    hold   <= 1'b0;
    h.cs_n <= 1'b0;
    h.rd_n <= 1'b0;
    ton = 0;
    toff = 0;
    @(posedge clock);
    while (dev_oe !== 1'b1 && ton < 20)
    begin
      @(posedge clock);
      ton++;
    end
    d = dev_data;
    repeat (2) @(posedge clock);
    h.rd_n <= 1'b1;
    h.cs_n <= 1'b1;
    @(posedge clock);
    while (dev_oe !== 1'b0 && toff < 20)
    begin
      @(posedge clock);
      toff++;
    end
    repeat (3) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// file: verif/muxed_bus_host_port_tb_top.sv
/*
  Testbench of the muxed bus host port.
  Assumes the host model and the design package.
*/
`timescale 1ns/1ps
`default_nettype none
module muxed_bus_host_port_tb_top;
  import mhp_pkg::*;
  // ******
  // Harness
  // ******
  logic       clock = 1'b0, rst_b = 1'b0, main_power = 1'b1;
  logic       wake_irq = 1'b0, wake_key_in_n = 1'b1, osc_in = 1'b0;
  mhp_host_s  h;
  logic [7:0] bus, dout, rd;
  logic       doe, poe, ioe, osc_out, ready, pout, iout;
  int         ton, toff, failures = 0, checked = 0, cyc = 0;
  always #5 clock = ~clock;
  // External oscillator and timeout
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc % 8 == 0)
      osc_in <= ~osc_in;
    if (cyc == 3000)
    begin
      failures++;
      final_report();
    end
  end
  mhp_host_model host (.clock(clock), .dev_data(dout), .dev_oe(doe),
                       .bus(bus), .h(h));
  mhp_port #(.LOCKOUT_CNT(20)) dut (
    .clock(clock), .rst_b(rst_b), .addr_latch_strobe(h.ale),
    .read_strobe_n(h.rd_n), .store_strobe_n(h.wr_n),
    .device_select_n(h.cs_n), .muxed_bus_in(bus), .muxed_bus_out(dout),
    .muxed_bus_oe(doe), .main_power(main_power), .wake_irq(wake_irq),
    .wake_key_in_n(wake_key_in_n), .power_on_ctl_n_out(pout),
    .power_on_ctl_n_oe(poe), .intr_request_n_out(iout),
    .intr_request_n_oe(ioe), .osc_in(osc_in), .osc_out(osc_out),
    .access_ready(ready));
  // Compare helpers and verdict
  task automatic cmp8(input string n, input logic [7:0] e, g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp1(input string n, input logic e, g);
    cmp8(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_ready();
    for (int n = 0; n < 60 && ready !== 1'b1; n++)
      @(posedge clock);
    cmp1("ready", 1'b1, ready);
  endtask
  // ******
  // Scenarios
  // ******
  // Quiet in reset, write during lockout refused
  task automatic t_lock();
    repeat (5) @(posedge clock);
    cmp1("oe in reset", 1'b0, doe);
    cmp1("ready in reset", 1'b0, ready);
    rst_b <= 1'b1;
    host.write(8'h01, 8'h5a, 1'b1);
    cmp1("ready early", 1'b0, ready);
    wait_ready();
    host.read(8'h01, rd, ton, toff);
    cmp8("locked write", 8'h00, rd);
  endtask
  // Back-to-back writes and reads, address 16 reads zero
  task automatic t_rw();
    logic [7:0] a [4] = '{8'h00, 8'h05, 8'h0f, 8'h10};
    logic [7:0] d [4] = '{8'h3c, 8'ha5, 8'hff, 8'h77};
    for (int i = 0; i < 4; i++)
      host.write(a[i], d[i], 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      host.read(a[i], rd, ton, toff);
      cmp8("read data", i == 3 ? 8'h00 : d[i], rd);
      cmp1("late drive", 1'b1, ton >= 2 && ton <= 6);
      cmp1("release", 1'b1, toff <= 4);
    end
    host.write(8'h05, 8'h11, 1'b0);
    host.read(8'h05, rd, ton, toff);
    cmp8("unselected", 8'ha5, rd);
  endtask
  // Power-on control by software, then by wake sources
  task automatic t_power();
    host.write(CTRL_ADDR, 8'h01, 1'b1);
    cmp1("pon sw on", 1'b1, poe);
    host.write(CTRL_ADDR, 8'h00, 1'b1);
    cmp1("pon sw off", 1'b0, poe);
    // Oscillator feedback once the input has settled
    while (cyc % 8 != 6)
      @(posedge clock);
    cmp1("osc run", ~osc_in, osc_out);
    main_power <= 1'b0;
    wake_irq <= 1'b1;
    repeat (6) @(posedge clock);
    cmp1("pon irq", 1'b1, poe);
    cmp1("pon level", 1'b0, pout);
    wake_irq <= 1'b0;
    wake_key_in_n <= 1'b0;
    repeat (6) @(posedge clock);
    cmp1("pon key", 1'b1, poe);
    wake_key_in_n <= 1'b1;
    main_power <= 1'b1;
    repeat (5) @(posedge clock);
    cmp1("relock", 1'b0, ready);
    wait_ready();
  endtask
  // Interrupt mask, set and clear; lockout bypass
  task automatic t_irq_byp();
    host.write(IEN_ADDR, 8'h01, 1'b1);
    host.write(FLAG_ADDR, 8'h02, 1'b1);
    cmp1("irq masked", 1'b0, ioe);
    host.write(FLAG_ADDR, 8'h01, 1'b1);
    cmp1("irq set", 1'b1, ioe);
    cmp1("irq level", 1'b0, iout);
    host.write(FLAG_ADDR, 8'h00, 1'b1);
    cmp1("irq clear", 1'b0, ioe);
    host.write(CTRL_ADDR, 8'h06, 1'b1);
    repeat (20) @(posedge clock);
    cmp1("osc off", 1'b0, osc_out);
    main_power <= 1'b0;
    repeat (4) @(posedge clock);
    main_power <= 1'b1;
    repeat (8) @(posedge clock);
    cmp1("bypass", 1'b1, ready);
  endtask
  // Main sequence
  initial
  begin
    t_lock();
    t_rw();
    t_power();
    t_irq_byp();
    final_report();
  end
endmodule
`default_nettype wire
